// ### verilog/pcs_pkg.sv
// Constants, field layout and types for the clock mode switcher
package pcs_pkg;
   // -----------------------------------------------------------------
   // Bus and register map
   // -----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int RATIO_W = 7;
   localparam logic [ADDR_W-1:0] CLK_MODE_OFS = 4'h0;
   localparam int LOCK_BIT = 16;       // Read-only loop locked view
   localparam int SEL_BIT = 1;
   localparam logic [15:0] CLK_MODE_RST = 16'h0000;
   localparam logic [3:0] MULT_QUARTER = 4'hf;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Register value loaded from the three straps, index {c,b,a}
   localparam logic [7:0][15:0] STRAP_TABLE = {
      16'h0804, 16'h1000, 16'h2004, 16'h2000,
      16'hf004, 16'h0004, 16'hf000, 16'h0000};

   // -----------------------------------------------------------------
   // Timing, counted in reference clock (mclk) cycles
   // -----------------------------------------------------------------
   localparam int REF_PER_TICK = 16;
   localparam logic [3:0] TICK_LAST = 4'(REF_PER_TICK - 1);
   localparam int SW_REF_CYC = 6;
   localparam int SW_REF_CYC_LONG = 12;
   localparam int LOOP_TAIL_HALVES = 7;  // 3.5 loop output cycles
   localparam int MCLK_PER_LOOP = 1;
   localparam int LOOP_TAIL_CYC = (LOOP_TAIL_HALVES * MCLK_PER_LOOP + 1) / 2;
   localparam logic [4:0] SW_DLY = 5'(SW_REF_CYC + LOOP_TAIL_CYC);
   localparam logic [4:0] SW_DLY_LONG = 5'(SW_REF_CYC_LONG + LOOP_TAIL_CYC);

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] multFactorField;
      logic       halfRatioField;
      logic [7:0] lockDelayCount;
      logic       loopPowerBit;
      logic       loopModeSelect;
      logic       activeModeFlag;
   } pcs_clk_mode_t;

   typedef enum logic [2:0] {
      ST_DIV, ST_LOCK_WAIT, ST_TO_LOOP, ST_LOOP, ST_TO_DIV
   } pcs_state_t;

   typedef enum logic [1:0] {SRC_HALF, SRC_QUARTER, SRC_LOOP} pcs_src_t;
endpackage

// ### verilog/pcs_mode_switcher.sv
// Clock mode switcher with lock timer, behind an AXI4-Lite slave
`timescale 1ns/1ps

// Overview of operation
// R1: Loop counts unlocked after reset, ratio change, power off, lost reference.
// R2: Lock survives divider mode while powered and ratio fields stay unchanged.
// R3: Setting mode select while unlocked with nonzero lock count starts the lock timer.
// R4: Ratio, count and power fields change only in divider mode.
// R5: Lock timer counts down from the preset lock count.
// R6: After timer hits zero, loop mode follows in 6 ref plus 3.5 loop cycles.
// R7: Active mode flag reads 1 once loop mode is reached.
// R8: Divider clocking continues while the lock timer runs.
// R9: Entering loop mode already locked skips the timer, short delay only.
// R10: Leaving loop mode never waits on the lock timer.
// R11: Divider mode follows in 6 ref plus 3.5 loop, 12 ref when mult is 15.
// R12: Active mode flag reads 0 once divider mode is reached.
// R13: Software returns to divider mode before choosing another loop ratio.
// R14: Software clears select, polls flag to 0, then writes new setup.
// R15: Software goes through loop mode between divide-by-2 and divide-by-4.
// R16: After reset the mode comes from the three strap pins.
// R17: Board straps enable the oscillator when a crystal is used.
// R18: Software sets ratio and lock count before entering unlocked loop mode.
// R19: Software should use the lock timer whenever the loop is unlocked.
// R20: Software confirms divider mode before powering the loop off.
// R21: Register holds mult 15:12, half 11, count 10:3, power, select, flag.
// R22: Lock timer decrements once per 16 reference cycles.
// R23: Loop is powered when power bit or mode select is 1.
// R24: Ratio follows divider, loop, bypass and half-ratio selection table.
// R25: Protected fields ignore writes in loop mode; select still updates.
// R26: Core clock changes source without glitches or runt pulses.
module pcs_mode_switcher (
   input  wire logic                        mclk,
   input  wire logic                        sys_rst,
   input  wire logic [pcs_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [pcs_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   input  wire logic                        modeStrapPinA,
   input  wire logic                        modeStrapPinB,
   input  wire logic                        modeStrapPinC,
   input  wire logic                        refClockLost,
   output logic                             coreClockOut,
   output logic                             loopPowerOut,
   output logic [pcs_pkg::RATIO_W-1:0]      coreRatioOut
);
   import pcs_pkg::*;

   pcs_clk_mode_t          cfgQ;
   pcs_state_t             stateQ;
   pcs_src_t               srcQ, srcD, srcWant;
   logic                   statQ, lockedQ, strapLoadQ;
   logic [7:0]             lockCntQ;
   logic [3:0]             preQ;
   logic [4:0]             dlyQ;
   logic [1:0]             phQ, phD;
   logic                   awHeldQ, wHeldQ;
   logic [ADDR_W-1:0]      awAddrQ;
   logic [31:0]            wDataQ;
   logic [3:0]             wStrbQ;
   logic                   awTake, wTake, arTake, doWrite, wrHit;
   logic [15:0]            wrWord;
   pcs_clk_mode_t          wrCfg;
   logic                   fieldChg, pwrOn;

   // -----------------------------------------------------------------
   // AXI4-Lite write channel
   // -----------------------------------------------------------------
   assign awTake = s_axi_awvalid && s_axi_awready;
   assign wTake = s_axi_wvalid && s_axi_wready;
   assign doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;
   assign wrHit = doWrite && (awAddrQ[ADDR_W-1:2] == CLK_MODE_OFS[ADDR_W-1:2]);
   // Byte lanes above the low two hold nothing writable
   assign wrWord = {wStrbQ[1] ? wDataQ[15:8] : cfgQ[15:8],
                    wStrbQ[0] ? wDataQ[7:0] : cfgQ[7:0]};
   assign wrCfg = pcs_clk_mode_t'(wrWord);

   // Address and data are taken in either order, held until both exist
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         awHeldQ <= 1'b0;
         wHeldQ <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         awAddrQ <= '0;
         wDataQ <= '0;
         wStrbQ <= '0;
      end else begin
         awHeldQ <= (awHeldQ || awTake) && !doWrite;
         wHeldQ <= (wHeldQ || wTake) && !doWrite;
         s_axi_awready <= !((awHeldQ || awTake) && !doWrite);
         s_axi_wready <= !((wHeldQ || wTake) && !doWrite);
         if (awTake) begin
            awAddrQ <= s_axi_awaddr;
         end
         if (wTake) begin
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
         end
      end
   end

   // Write response, slave error for an unmapped word
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite read channel
   // -----------------------------------------------------------------
   assign arTake = s_axi_arvalid && s_axi_arready;

   // Data is captured at the address edge, so a read sees one snapshot
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !((s_axi_rvalid && !s_axi_rready) || arTake);
         if (arTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
            if (s_axi_araddr[ADDR_W-1:2] == CLK_MODE_OFS[ADDR_W-1:2]) begin
               s_axi_rdata[15:0] <= {cfgQ[15:1], statQ}; // see R21
               s_axi_rdata[LOCK_BIT] <= lockedQ;
               s_axi_rresp <= RESP_OKAY;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Clock mode register
   // -----------------------------------------------------------------
   // Straps are caught the cycle after reset, never inside reset itself
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfgQ <= pcs_clk_mode_t'(CLK_MODE_RST);
         strapLoadQ <= 1'b1;
      end else if (strapLoadQ) begin
         strapLoadQ <= 1'b0;
         cfgQ <= pcs_clk_mode_t'(STRAP_TABLE[{modeStrapPinC, modeStrapPinB,
                                              modeStrapPinA}]); // see R16
      end else if (wrHit) begin
         cfgQ.loopModeSelect <= wrWord[SEL_BIT]; // see R25
         if (stateQ == ST_DIV) begin // see R4
            cfgQ.multFactorField <= wrCfg.multFactorField;
            cfgQ.halfRatioField <= wrCfg.halfRatioField;
            cfgQ.lockDelayCount <= wrCfg.lockDelayCount;
            cfgQ.loopPowerBit <= wrCfg.loopPowerBit;
         end
      end
   end

   // -----------------------------------------------------------------
   // Loop lock tracking
   // -----------------------------------------------------------------
   assign pwrOn = cfgQ.loopPowerBit || cfgQ.loopModeSelect; // see R23
   assign fieldChg = wrHit && (stateQ == ST_DIV) &&
      ({wrCfg.multFactorField, wrCfg.halfRatioField} !=
       {cfgQ.multFactorField, cfgQ.halfRatioField});

   // Any loss event beats a lock report in the same cycle
   always_ff @(posedge mclk) begin
      if (sys_rst || strapLoadQ) begin
         lockedQ <= 1'b0; // see R1
      end else if (fieldChg || !pwrOn || refClockLost) begin
         lockedQ <= 1'b0; // see R1
      end else if (stateQ == ST_TO_LOOP && dlyQ == 5'h01) begin
         lockedQ <= 1'b1; // see R2
      end
   end

   // -----------------------------------------------------------------
   // Mode sequencer
   // -----------------------------------------------------------------
   // The lock timer only delays; clocking stays in divider mode meanwhile
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stateQ <= ST_DIV;
         statQ <= 1'b0;
         lockCntQ <= '0;
         preQ <= '0;
         dlyQ <= '0;
      end else begin
         unique case (stateQ)
            ST_DIV: begin
               if (cfgQ.loopModeSelect && !strapLoadQ) begin
                  preQ <= '0;
                  lockCntQ <= cfgQ.lockDelayCount; // see R5
                  dlyQ <= SW_DLY;
                  if (!lockedQ && cfgQ.lockDelayCount != 8'h00) begin
                     stateQ <= ST_LOCK_WAIT; // see R3
                  end else begin
                     stateQ <= ST_TO_LOOP; // see R9
                  end
               end
            end
            ST_LOCK_WAIT: begin
               preQ <= preQ + 4'h1;
               if (!cfgQ.loopModeSelect) begin
                  stateQ <= ST_DIV;
               end else if (preQ == TICK_LAST) begin // see R22
                  lockCntQ <= lockCntQ - 8'h01; // see R5
                  if (lockCntQ == 8'h01) begin
                     stateQ <= ST_TO_LOOP; // see R6
                  end
               end
            end
            ST_TO_LOOP: begin
               dlyQ <= dlyQ - 5'h01;
               if (dlyQ == 5'h01) begin
                  stateQ <= ST_LOOP;
                  statQ <= 1'b1; // see R7
               end
            end
            ST_LOOP: begin
               if (!cfgQ.loopModeSelect) begin // see R10
                  stateQ <= ST_TO_DIV;
                  dlyQ <= (cfgQ.multFactorField == MULT_QUARTER) ?
                          SW_DLY_LONG : SW_DLY; // see R11
               end
            end
            ST_TO_DIV: begin
               dlyQ <= dlyQ - 5'h01;
               if (dlyQ == 5'h01) begin
                  stateQ <= ST_DIV;
                  statQ <= 1'b0; // see R12
               end
            end
            default: begin
               stateQ <= ST_DIV;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Core clock and ratio outputs
   // -----------------------------------------------------------------
   // Ratio in quarters of the reference frequency
   function automatic logic [RATIO_W-1:0] ratioOf(pcs_clk_mode_t c,
                                                   logic loop);
      logic [RATIO_W-1:0] m;
      m = {3'h0, c.multFactorField};
      if (!loop) begin
         ratioOf = (c.multFactorField == MULT_QUARTER) ? 7'h01 : 7'h02;
      end else if (!c.halfRatioField) begin
         ratioOf = (c.multFactorField == MULT_QUARTER) ? 7'h04 :
                   7'((m + 7'h01) << 2);
      end else if (!c.multFactorField[0]) begin
         ratioOf = 7'((m + 7'h01) << 1);
      end else begin
         ratioOf = m;
      end
   endfunction

   // Source may change only when both candidates are about to fall low
   always_comb begin
      srcWant = statQ ? SRC_LOOP : // see R8
         ((cfgQ.multFactorField == MULT_QUARTER) ? SRC_QUARTER : SRC_HALF);
      phD = phQ + 2'h1;
      srcD = (phQ == 2'h3) ? srcWant : srcQ; // see R26
   end

   // The loop oscillator itself is analog; its slot here is a stand-in
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         phQ <= '0;
         srcQ <= SRC_HALF;
         coreClockOut <= 1'b0;
      end else begin
         phQ <= phD;
         srcQ <= srcD;
         coreClockOut <= (srcD == SRC_QUARTER) ? phD[1] : phD[0];
      end
   end

   // Power and ratio reported to the analog loop
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         loopPowerOut <= 1'b0;
         coreRatioOut <= '0;
      end else begin
         loopPowerOut <= pwrOn; // see R23
         coreRatioOut <= ratioOf(cfgQ, statQ); // see R24
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_prot_fields: assert property (wrHit && stateQ != ST_DIV |=> // see R4
      $stable({cfgQ.multFactorField, cfgQ.halfRatioField,
               cfgQ.lockDelayCount, cfgQ.loopPowerBit}))
      else $error("protected field changed outside divider mode");
   a_sel_update: assert property (wrHit && !strapLoadQ |=> // see R25
      cfgQ.loopModeSelect == $past(wrWord[SEL_BIT]))
      else $error("mode select not updated by write");
   a_unlock_off: assert property (!pwrOn || refClockLost |=> // see R1
      !lockedQ) else $error("lock kept after power off or lost ref");
   a_lock_keep: assert property (lockedQ && pwrOn && !fieldChg // see R2
      && !refClockLost && !strapLoadQ |=> lockedQ)
      else $error("lock dropped without cause");
   a_timer_start: assert property (stateQ == ST_DIV && // see R3
      cfgQ.loopModeSelect && !lockedQ && !strapLoadQ &&
      cfgQ.lockDelayCount != 8'h00 |=> stateQ == ST_LOCK_WAIT)
      else $error("lock timer not started");
   a_timer_tick: assert property (stateQ == ST_LOCK_WAIT && // see R22
      cfgQ.loopModeSelect && preQ == 4'hf |=>
      lockCntQ == $past(lockCntQ) - 8'h01)
      else $error("lock timer tick wrong");
   a_wait_div: assert property (stateQ == ST_LOCK_WAIT |-> // see R8
      !statQ && srcQ != SRC_LOOP) else $error("loop clock during wait");
   a_loop_delay: assert property ($rose(stateQ == ST_TO_LOOP) |-> // see R6
      ##9 !statQ ##1 statQ) else $error("loop entry delay wrong");
   a_div_delay: assert property ($rose(stateQ == ST_TO_DIV) && // see R11
      cfgQ.multFactorField != MULT_QUARTER |-> ##9 statQ ##1 !statQ)
      else $error("divider entry delay wrong");
   a_div_long: assert property ($rose(stateQ == ST_TO_DIV) && // see R11
      cfgQ.multFactorField == MULT_QUARTER |-> ##15 statQ ##1 !statQ)
      else $error("long divider entry delay wrong");
   a_no_runt: assert property (srcQ != $past(srcQ) |-> // see R26
      phQ == 2'h0 && !coreClockOut) else $error("source changed mid-phase");

   c_locked_entry: cover property (stateQ == ST_DIV && lockedQ
      ##1 stateQ == ST_TO_LOOP);
   c_timed_entry: cover property (stateQ == ST_LOCK_WAIT
      ##1 stateQ == ST_TO_LOOP);
   c_long_exit: cover property ($rose(stateQ == ST_TO_DIV) &&
      cfgQ.multFactorField == MULT_QUARTER);
   c_prot_write: cover property (wrHit && stateQ == ST_LOOP);
endmodule

// ### verification/pcs_core_model.sv
// Core model clocked by the generated clock, watching its phases
`timescale 1ns/1ps

module pcs_core_model (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic coreClockOut,
   output int        coreEdges,
   output int        minPhase
);
   int   runLen;
   logic lastLvl;
   logic seenEdge;

   // ----------------------------------------------------------------
   // Core side
   // ----------------------------------------------------------------
   // The core only counts its own clock edges, like a real program counter
   always @(posedge coreClockOut or posedge sys_rst) begin
      if (sys_rst) begin
         coreEdges <= 0;
      end else begin
         coreEdges <= coreEdges + 1;
      end
   end

   // Shortest level seen, in mclk cycles; the first partial phase is skipped
   always @(posedge mclk) begin
      if (sys_rst) begin
         runLen   <= 0;
         lastLvl  <= coreClockOut;
         seenEdge <= 1'b0;
         minPhase <= 99;
      end else if (coreClockOut !== lastLvl) begin
         if (seenEdge && runLen < minPhase) begin
            minPhase <= runLen;
         end
         seenEdge <= 1'b1;
         lastLvl  <= coreClockOut;
         runLen   <= 1;
      end else begin
         runLen <= runLen + 1;
      end
   end
endmodule

// ### verification/pcs_mode_switcher_test.sv
// Self-checking bench for the clock mode switcher over AXI4-Lite
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin numChecks++; if ((got) !== (exp)) begin \
   errTotal++; $display("Error %s expected %h seen %h", nm, exp, got); end end

module pcs_mode_switcher_test;
   import pcs_pkg::*;
   logic        mclk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, rsp;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        strapA, strapB, strapC, refLost, coreClk, loopPwr;
   logic [RATIO_W-1:0] ratio;
   int          errTotal, numChecks, coreEdges, minPhase, m;

   pcs_mode_switcher u_dut (.mclk(mclk), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .modeStrapPinA(strapA), .modeStrapPinB(strapB), .modeStrapPinC(strapC),
      .refClockLost(refLost), .coreClockOut(coreClk),
      .loopPowerOut(loopPwr), .coreRatioOut(ratio));

   pcs_core_model u_core (.mclk(mclk), .sys_rst(sys_rst),
      .coreClockOut(coreClk), .coreEdges(coreEdges), .minPhase(minPhase));

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   // Address and data offered together, each released once taken
   task automatic axWr(input logic [3:0] a, input logic [31:0] d,
                       output logic [1:0] r);
      int n;
      n = 0;
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge mclk);
         n++;
         // Lower each valid once only, so a next call never drives it twice
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            break;
         end
      end
   endtask

   task automatic axRd(input logic [3:0] a, output logic [31:0] d,
                       output logic [1:0] r);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge mclk);
         // Ready stays up between reads; back to back calls need no toggle
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            break;
         end
      end
   endtask

   // Read the register and compare the whole word
   task automatic rdChk(input logic [31:0] exp);
      axRd(CLK_MODE_OFS, rd, rsp);
      `CHK("clock mode word", exp, rd)
   endtask

   // Cycles until the ratio output settles, checked against the timing
   task automatic waitRatio(input logic [RATIO_W-1:0] r, input int e);
      m = 0;
      while (ratio !== r && m < 5000) begin
         @(posedge mclk);
         m++;
      end
      `CHK("switch delay in range", 1'b1, (m >= e - 1 && m <= e + 3))
   endtask

   // Clear select and poll the flag down to divider mode
   task automatic toDiv(input logic [31:0] d);
      axWr(CLK_MODE_OFS, d, rsp);
      rd = 32'h1;
      for (int i = 0; i < 100 && rd[0] !== 1'b0; i++) begin
         axRd(CLK_MODE_OFS, rd, rsp);
      end
   endtask

   task automatic giveVerdict;
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // The whole run needs well under two thousand cycles
   initial begin
      #(25 * 20000);
      errTotal++;
      giveVerdict;
   end

   initial begin
      sys_rst = 1'b1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
      rready = 0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0;
      wstrb = 4'hf; refLost = 0; strapA = 0; strapB = 1; strapC = 0;
      errTotal = 0; numChecks = 0;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge mclk);
      rdChk({16'h0, STRAP_TABLE[2]});
      `CHK("loop power", 1'b1, loopPwr)
      $display("test straps done");

      axWr(CLK_MODE_OFS, 32'h2016, rsp);
      repeat (16) @(posedge mclk);
      `CHK("ratio during lock wait", 7'd2, ratio)
      `CHK("core still clocked", 1'b1, coreEdges > 8)
      waitRatio(7'd12, 2 * REF_PER_TICK + 10 - 16);
      rdChk(32'h12017);
      axWr(CLK_MODE_OFS, 32'h5002, rsp);
      rdChk(32'h12017);
      $display("test unlocked entry done");

      axWr(CLK_MODE_OFS, 32'h0004, rsp);
      waitRatio(7'd2, 10);
      rdChk(32'h12014);
      axWr(CLK_MODE_OFS, 32'h2016, rsp);
      waitRatio(7'd12, 10);
      toDiv(32'h2004);
      `CHK("flag back to divider", 1'b0, rd[0])
      @(posedge mclk);
      refLost <= 1'b1;
      @(posedge mclk);
      refLost <= 1'b0;
      rdChk(32'h2014);
      $display("test locked entry done");

      axWr(CLK_MODE_OFS, 32'h0000, rsp);
      repeat (3) @(posedge mclk);
      `CHK("loop power off", 1'b0, loopPwr)
      axWr(CLK_MODE_OFS, 32'hf006, rsp);
      waitRatio(7'd4, 10);
      rdChk(32'h1f007);
      axWr(CLK_MODE_OFS, 32'hf004, rsp);
      waitRatio(7'd1, 16);
      // Let the source settle, then a quarter clock rises once per 4 cycles
      repeat (8) @(posedge mclk);
      m = coreEdges;
      repeat (16) @(posedge mclk);
      `CHK("quarter clock edges", 4, coreEdges - m)
      $display("test quarter mode done");

      axWr(4'h4, 32'h1234, rsp);
      `CHK("unmapped write resp", RESP_SLVERR, rsp)
      axRd(4'h8, rd, rsp);
      `CHK("unmapped read resp", RESP_SLVERR, rsp)
      `CHK("unmapped read data", 32'h0, rd)
      `CHK("no runt phase", 1'b1, minPhase >= 1)
      $display("test bus errors done");
      giveVerdict;
   end
endmodule
